//--- can_channel_status_irq.sv
// status flags, flag clearing and interrupt mask of one can channel
// assumes event pulses synchronous to clk_sys, one cycle each
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps

// Functional notes
// - missing acknowledge sets flag bit 0
// - illegal fixed-form bit sets bit 1
// - crc mismatch sets bit 2
// - six equal bits set bit 3
// - dominant sent, recessive seen sets bit 4
// - error-free reception sets bit 5
// - error-free transmission sets bit 6
// - remote frame sets bit 7 early
// - dlc mismatch sets bit 9, no interrupt
// - overwrite consumer reception sets bit 10
// - overwrite consumer reception while filled sets bit 11
// - write one clears flag and interrupt
// - clear register also clears filled, overrun
// - enable register write one enables interrupt
// - disable register write one disables interrupt
// - mask view reads enabled interrupts
// - normal mode disables channel after reception
// - producer bit returns zero after transmission
// - received dlc updates control field
module can_channel_status_irq (
	// clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	// register port
	input  wire logic [7:0]                    addr,
	input  wire logic [31:0]                   wdata,
	input  wire logic                          wr,
	input  wire logic                          rd,
	output logic      [31:0]                   rdata_reg,
	// protocol engine side
	input  wire can_chan_pkg::can_event_t      ev,
	output can_chan_pkg::channel_control_t     cfg,
	// interrupt
	output logic                               irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	can_chan_pkg::channel_control_t ctrl_reg;
	can_chan_pkg::channel_control_t ctrl_next;
	can_chan_pkg::channel_control_t ctrl_sw;
	logic [11:0] flags;
	logic [11:0] set_vec;
	logic [11:0] clr_vec;
	logic [7:0]  mask_reg;
	logic [7:0]  mask_next;
	logic [31:0] rdata_next;
	logic [31:0] rd_val;
	logic        hit_ctrl;
	logic        hit_clear;
	logic        hit_flags;
	logic        hit_en;
	logic        hit_dis;
	logic        hit_view;
	logic        dlc_mismatch;
	logic        fill_set;
	logic        ovr_set;

	////////////////////////////////////////////////////////////////////////
	// address decode

	assign hit_ctrl  = (addr == can_chan_pkg::OFS_CHANNEL_CONTROL);
	assign hit_clear = (addr == can_chan_pkg::OFS_FLAG_CLEAR);
	assign hit_flags = (addr == can_chan_pkg::OFS_EVENT_FLAGS);
	assign hit_en    = (addr == can_chan_pkg::OFS_IRQ_ENABLE_SET);
	assign hit_dis   = (addr == can_chan_pkg::OFS_IRQ_ENABLE_CLEAR);
	assign hit_view  = (addr == can_chan_pkg::OFS_IRQ_ENABLED_VIEW);

	////////////////////////////////////////////////////////////////////////
	// event set terms

	assign dlc_mismatch = ev.frame_accepted & (ev.rx_dlc != ctrl_reg.dlc);
	assign fill_set     = ev.rx_done & ctrl_reg.overwrite & ~ctrl_reg.producer_select;
	assign ovr_set      = fill_set & flags[can_chan_pkg::BIT_BUFFER_FILLED];

	assign set_vec[can_chan_pkg::BIT_ACK_ERR]         = ev.ack_err;
	assign set_vec[can_chan_pkg::BIT_FORM_ERR]        = ev.form_err;
	assign set_vec[can_chan_pkg::BIT_CRC_ERR]         = ev.crc_err;
	assign set_vec[can_chan_pkg::BIT_STUFF_ERR]       = ev.stuff_err;
	assign set_vec[can_chan_pkg::BIT_BIT_ERR]         = ev.bit_err;
	assign set_vec[can_chan_pkg::BIT_RX_DONE]         = ev.rx_done;
	assign set_vec[can_chan_pkg::BIT_TX_DONE]         = ev.tx_done;
	assign set_vec[can_chan_pkg::BIT_REMOTE_ARRIVAL]  = ev.remote_start;
	assign set_vec[8]                                 = 1'b0;
	assign set_vec[can_chan_pkg::BIT_LENGTH_MISMATCH] = dlc_mismatch;
	assign set_vec[can_chan_pkg::BIT_BUFFER_FILLED]   = fill_set;
	assign set_vec[can_chan_pkg::BIT_BUFFER_OVERRUN]  = ovr_set;

	// write one clears, zero leaves alone
	assign clr_vec = (wr && hit_clear) ? (wdata[11:0] & can_chan_pkg::FLAG_IMPL_MASK) : 12'h000;

	////////////////////////////////////////////////////////////////////////
	// sticky flags

	genvar gi;
	generate
		for (gi = 0; gi < can_chan_pkg::FLAG_W; gi++) begin : g_flag
			flag_cell u_flag (
				.clk_sys  (clk_sys),
				.rst      (rst),
				.set_in   (set_vec[gi]),
				.clr_in   (clr_vec[gi]),
				.flag_reg (flags[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// interrupt mask

	assign mask_next = (wr && hit_en)  ? (mask_reg | wdata[7:0]) :
	                   (wr && hit_dis) ? (mask_reg & ~wdata[7:0]) :
	                   mask_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mask_reg <= can_chan_pkg::MASK_RESET;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// only the eight event flags reach the line
	assign irq = |(flags[7:0] & mask_reg);

	////////////////////////////////////////////////////////////////////////
	// channel control

	assign ctrl_sw = (wr && hit_ctrl) ? can_chan_pkg::channel_control_t'(wdata[8:0]) : ctrl_reg;

	always_comb begin
		ctrl_next = ctrl_sw;
		if (ev.rx_done && !ctrl_reg.overwrite) begin
			ctrl_next.chan_en = 1'b0;
		end
		if (ev.tx_done) begin
			ctrl_next.producer_select = 1'b0;
		end
		if (ev.frame_accepted) begin
			ctrl_next.dlc = ev.rx_dlc;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_reg <= can_chan_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign cfg = ctrl_reg;

	////////////////////////////////////////////////////////////////////////
	// read path

	assign rd_val = hit_flags ? {20'h00000, flags} :
	                hit_ctrl  ? {23'h000000, ctrl_reg} :
	                hit_view  ? {24'h000000, mask_reg} :
	                can_chan_pkg::RDATA_IDLE;

	assign rdata_next = rd ? rd_val : can_chan_pkg::RDATA_IDLE;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_reg <= can_chan_pkg::RDATA_IDLE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	chk_ack_set: assert property (
		ev.ack_err |=> flags[0]
	) else $error("ack error flag not set");

	chk_form_set: assert property (
		ev.form_err |=> flags[1]
	) else $error("form error flag not set");

	chk_crc_set: assert property (
		ev.crc_err |=> flags[2]
	) else $error("crc error flag not set");

	chk_stuff_set: assert property (
		ev.stuff_err |=> flags[3]
	) else $error("stuffing error flag not set");

	chk_bit_set: assert property (
		ev.bit_err |=> flags[4]
	) else $error("bit error flag not set");

	chk_rx_set: assert property (
		ev.rx_done |=> flags[5]
	) else $error("receive done flag not set");

	chk_tx_set: assert property (
		ev.tx_done |=> flags[6]
	) else $error("transmit done flag not set");

	chk_remote_set: assert property (
		ev.remote_start |=> flags[7]
	) else $error("remote flag not set");

	chk_length_warn: assert property (
		ev.frame_accepted && (ev.rx_dlc != cfg.dlc) |=> flags[9]
	) else $error("length warning not set");

	chk_length_quiet: assert property (
		flags[9] && !(|(flags[7:0] & mask_reg)) |-> !irq
	) else $error("length warning drove interrupt");

	chk_filled_mode: assert property (
		$rose(flags[10]) |-> $past(cfg.overwrite) && !$past(cfg.producer_select)
	) else $error("filled flag outside overwrite consumer");

	chk_overrun_cause: assert property (
		$rose(flags[11]) |-> $past(flags[10]) && $past(ev.rx_done)
	) else $error("overrun without filled buffer");

	chk_clear_ack: assert property (
		wr && hit_clear && wdata[0] && !ev.ack_err |=> !flags[0] && !(flags[0] && mask_reg[0])
	) else $error("ack flag survived clear");

	chk_clear_zero: assert property (
		wr && hit_clear && !wdata[5] && flags[5] |=> flags[5]
	) else $error("write zero cleared a flag");

	chk_clear_filled: assert property (
		wr && hit_clear && wdata[10] && wdata[11] && !ev.rx_done |=> !flags[10] && !flags[11]
	) else $error("filled or overrun survived clear");

	chk_enable_irq: assert property (
		wr && hit_en && wdata[6] && flags[6] && !(wr && hit_clear) ##1 flags[6] |-> irq
	) else $error("enabled event gave no interrupt");

	chk_disable_mask: assert property (
		wr && hit_dis && wdata[3] |=> !mask_reg[3]
	) else $error("disable write left interrupt on");

	chk_view_read: assert property (
		rd && hit_view |=> rdata_reg == {24'h000000, $past(mask_reg)}
	) else $error("mask view read wrong");

	chk_irq_hold: assert property (
		irq && !wr |=> irq
	) else $error("interrupt dropped without clear or mask");

	chk_normal_off: assert property (
		ev.rx_done && !cfg.overwrite |=> !cfg.chan_en
	) else $error("channel still enabled after reception");

	chk_overwrite_on: assert property (
		ev.rx_done && cfg.overwrite && cfg.chan_en && !wr |=> cfg.chan_en
	) else $error("overwrite channel disabled");

	chk_producer_ret: assert property (
		ev.tx_done |=> !cfg.producer_select
	) else $error("producer bit not returned");

	chk_dlc_update: assert property (
		ev.frame_accepted |=> cfg.dlc == $past(ev.rx_dlc)
	) else $error("dlc not updated from frame");

	chk_rdata_idle: assert property (
		!rd |=> rdata_reg == 32'h0000_0000
	) else $error("read data outside read slot");

	chk_flag_sticky: assert property (
		flags[0] && !(wr && hit_clear && wdata[0]) |=> flags[0]
	) else $error("ack flag lost without clear");

	chk_clear_tx: assert property (
		wr && hit_clear && wdata[6] && !ev.tx_done |=> !flags[6]
	) else $error("transmit flag survived clear");

	chk_filled_set: assert property (
		ev.rx_done && cfg.overwrite && !cfg.producer_select |=> flags[10]
	) else $error("filled flag not set in overwrite consumer");

	chk_overrun_set: assert property (
		ev.rx_done && cfg.overwrite && !cfg.producer_select && flags[10] |=> flags[11]
	) else $error("overrun flag not set on filled buffer");

	chk_filled_stay: assert property (
		flags[10] && !(wr && hit_clear && wdata[10]) |=> flags[10]
	) else $error("filled flag lost without clear");

	chk_length_cause: assert property (
		$rose(flags[9]) |-> $past(ev.frame_accepted)
	) else $error("length warning without accepted frame");

	chk_enable_bit: assert property (
		wr && hit_en && wdata[2] |=> mask_reg[2]
	) else $error("enable write left mask bit off");

	chk_disable_all: assert property (
		wr && hit_dis && (wdata[7:0] == 8'hFF) |=> !irq
	) else $error("interrupt after full disable");

	chk_mask_stable: assert property (
		!(wr && (hit_en || hit_dis)) |=> $stable(mask_reg)
	) else $error("mask changed without mask write");

	chk_irq_source: assert property (
		flags[3] && mask_reg[3] |-> irq
	) else $error("enabled stuffing flag gave no interrupt");

	chk_producer_keep: assert property (
		!ev.tx_done && !(wr && hit_ctrl) |=> $stable(cfg.producer_select)
	) else $error("producer bit moved without cause");

	chk_dlc_hold: assert property (
		!ev.frame_accepted && !(wr && hit_ctrl) |=> $stable(cfg.dlc)
	) else $error("length code moved without frame");

	cov_rx_irq: cover property (
		mask_reg[5] ##0 ev.rx_done ##1 irq
	);

	cov_overrun: cover property (
		fill_set ##[1:20] ovr_set
	);

	cov_remote_seq: cover property (
		ev.remote_start ##[1:50] ev.rx_done
	);

	cov_set_vs_clear: cover property (
		ev.ack_err && wr && hit_clear && wdata[0]
	);

endmodule : can_channel_status_irq

//--- can_chan_pkg.sv
// constants and carriers for one can message channel status block
// assumes a byte-addressed register port with 32-bit data
package can_chan_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FLAG_W = 12;
	localparam int IRQ_W  = 8;
	localparam int CTRL_W = 9;
	localparam int DLC_W  = 4;

	// register byte offsets
	localparam logic [7:0] OFS_CHANNEL_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_FLAG_CLEAR         = 8'h08;
	localparam logic [7:0] OFS_EVENT_FLAGS        = 8'h0C;
	localparam logic [7:0] OFS_IRQ_ENABLE_SET     = 8'h10;
	localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR   = 8'h14;
	localparam logic [7:0] OFS_IRQ_ENABLED_VIEW   = 8'h18;

	// event flag bit positions
	localparam int BIT_ACK_ERR         = 0;
	localparam int BIT_FORM_ERR        = 1;
	localparam int BIT_CRC_ERR         = 2;
	localparam int BIT_STUFF_ERR       = 3;
	localparam int BIT_BIT_ERR         = 4;
	localparam int BIT_RX_DONE         = 5;
	localparam int BIT_TX_DONE         = 6;
	localparam int BIT_REMOTE_ARRIVAL  = 7;
	localparam int BIT_LENGTH_MISMATCH = 9;
	localparam int BIT_BUFFER_FILLED   = 10;
	localparam int BIT_BUFFER_OVERRUN  = 11;

	// implemented flag bits, bit 8 is reserved
	localparam logic [11:0] FLAG_IMPL_MASK = 12'hEFF;

	// reset values
	localparam logic [11:0] FLAGS_RESET = 12'h000;
	localparam logic [7:0]  MASK_RESET  = 8'h00;
	localparam logic [8:0]  CTRL_RESET  = 9'h000;
	localparam logic [31:0] RDATA_IDLE  = 32'h0000_0000;

	// channel control layout, bit 8 down to bit 0
	typedef struct packed {
		logic       overwrite;
		logic       chan_en;
		logic       producer_select;
		logic       auto_reply;
		logic       ide;
		logic [3:0] dlc;
	} channel_control_t;

	// one-cycle event pulses from the protocol engine
	typedef struct packed {
		logic       ack_err;
		logic       form_err;
		logic       crc_err;
		logic       stuff_err;
		logic       bit_err;
		logic       rx_done;
		logic       tx_done;
		logic       remote_start;
		logic       frame_accepted;
		logic [3:0] rx_dlc;
	} can_event_t;

endpackage : can_chan_pkg

//--- flag_cell.sv
// one sticky status bit, set by hardware, cleared by software
// assumes set and clear are single-cycle pulses on clk_sys
`timescale 1ns/10ps
module flag_cell (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// control
	input  wire logic set_in,
	input  wire logic clr_in,
	// state
	output logic      flag_reg
);

	logic flag_next;

	// set beats a clear in the same cycle
	assign flag_next = set_in | (flag_reg & ~clr_in);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

endmodule : flag_cell

//--- can_engine_model.sv
// engine stand-in: one-cycle event pulses on command
// assumes commands come from the bench just after clk_sys edges
`timescale 1ns/10ps
module can_engine_model (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// command
	input  wire logic                go,
	input  wire logic [3:0]          kind,
	input  wire logic [3:0]          dlc,
	// events
	output can_chan_pkg::can_event_t ev
);
	////////////////////////////////////////////////////////////////
	// kind 0..7 matches flag bit, 8 is frame accepted
	// length field only meaningful with a pulse, inverted otherwise
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ev <= '0;
		end else begin
			ev <= go ? {9'h100 >> kind, dlc} : {9'h000, ~dlc};
		end
	end
endmodule : can_engine_model

//--- can_channel_status_irq_tb.sv
// self-checking bench for the channel status block
// assumes the engine model and the design package are compiled first
`timescale 1ns/10ps
module can_channel_status_irq_tb;
	logic                           clk_sys;
	logic                           rst;
	logic [7:0]                     addr;
	logic [31:0]                    wdata;
	logic                           wr;
	logic                           rd;
	logic [31:0]                    rdata_reg;
	logic                           go;
	logic [3:0]                     kind;
	logic [3:0]                     dlc;
	can_chan_pkg::can_event_t       ev;
	can_chan_pkg::channel_control_t cfg;
	logic                           irq;
	logic [31:0]                    rv;
	logic [31:0]                    m;
	logic [3:0]                     n;
	int                             fail_count;
	int                             check_count;

	can_engine_model can_engine_model_inst (.clk_sys(clk_sys), .rst(rst), .go(go), .kind(kind), .dlc(dlc), .ev(ev));
	can_channel_status_irq can_channel_status_irq_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_reg(rdata_reg), .ev(ev), .cfg(cfg), .irq(irq));

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] bit_of(input int k);
		return 32'h1 << k;
	endfunction : bit_of
	function automatic logic [31:0] ctrl_word(input logic ow, input logic en, input logic ps, input logic [3:0] d);
		return {23'h0, ow, en, ps, 2'b00, d};
	endfunction : ctrl_word
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata_reg;
	endtask : rd_reg
	task automatic fire(input int k, input logic [3:0] d);
		@(posedge clk_sys);
		go <= 1'b1;
		kind <= k[3:0];
		dlc <= d;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask : fire
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		complete_run();
	end
	initial begin
		fail_count = 0;
		check_count = 0;
		m = $urandom(32'h2E8B8258);
		{rst, addr, wdata, wr, rd, go, kind, dlc} = {1'b1, 51'h0};
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		// reset values, unmapped and write-only places
		rd_reg(can_chan_pkg::OFS_EVENT_FLAGS, rv);
		check("flags", rv, 32'h0);
		rd_reg(can_chan_pkg::OFS_IRQ_ENABLED_VIEW, rv);
		check("mask", rv, 32'h0);
		rd_reg(can_chan_pkg::OFS_CHANNEL_CONTROL, rv);
		check("ctrl", rv, 32'h0);
		rd_reg(8'h04, rv);
		check("unmapped", rv, 32'h0);
		rd_reg(can_chan_pkg::OFS_FLAG_CLEAR, rv);
		check("clr_rd", rv, 32'h0);
		// each of the eight interrupt events (kinds 0..7): enable, zero-clear, one-clear, disable, masked
		for (int k = 0; k < 8; k++) begin
			wr_reg(can_chan_pkg::OFS_IRQ_ENABLE_SET, bit_of(k));
			rd_reg(can_chan_pkg::OFS_IRQ_ENABLED_VIEW, rv);
			check("view", rv, bit_of(k));
			fire(k, 4'h0);
			check("irq_on", irq, 32'h1);
			rd_reg(can_chan_pkg::OFS_EVENT_FLAGS, rv);
			check("flag", rv, bit_of(k));
			wr_reg(can_chan_pkg::OFS_FLAG_CLEAR, $urandom & ~bit_of(k));
			check("zero_clr", irq, 32'h1);
			wr_reg(can_chan_pkg::OFS_FLAG_CLEAR, bit_of(k));
			check("one_clr", irq, 32'h0);
			wr_reg(can_chan_pkg::OFS_IRQ_ENABLE_CLEAR, bit_of(k));
			fire(k, 4'h0);
			check("masked", irq, 32'h0);
			wr_reg(can_chan_pkg::OFS_EVENT_FLAGS, 32'hFFFF_FFFF);
			wr_reg(can_chan_pkg::OFS_FLAG_CLEAR, 32'hFF);
			rd_reg(can_chan_pkg::OFS_EVENT_FLAGS, rv);
			check("cleared", rv, 32'h0);
		end
		// overwrite consumer: length warning, filled, overrun
		n = 4'($urandom_range(8, 0));
		wr_reg(can_chan_pkg::OFS_CHANNEL_CONTROL, ctrl_word(1'b1, 1'b1, 1'b0, n));
		rd_reg(can_chan_pkg::OFS_CHANNEL_CONTROL, rv);
		check("ctrl_rd", rv, ctrl_word(1'b1, 1'b1, 1'b0, n));
		fire(8, (n == 4'h8) ? 4'h0 : n + 4'h1);
		check("dlc", cfg.dlc, (n == 4'h8) ? 32'h0 : n + 4'h1);
		fire(5, 4'h0);
		fire(5, 4'h0);
		check("en_kept", cfg.chan_en, 32'h1);
		wr_reg(can_chan_pkg::OFS_IRQ_ENABLE_SET, 32'hFF);
		wr_reg(can_chan_pkg::OFS_FLAG_CLEAR, bit_of(5));
		rd_reg(can_chan_pkg::OFS_EVENT_FLAGS, rv);
		check("ovw", rv, 32'hE00);
		check("no_irq", irq, 32'h0);
		wr_reg(can_chan_pkg::OFS_FLAG_CLEAR, 32'hE00);
		rd_reg(can_chan_pkg::OFS_EVENT_FLAGS, rv);
		check("ovw_clr", rv, 32'h0);
		// normal mode producer, then remote reception
		wr_reg(can_chan_pkg::OFS_CHANNEL_CONTROL, ctrl_word(1'b0, 1'b1, 1'b1, 4'h0));
		fire(6, 4'h0);
		check("pcb", cfg.producer_select, 32'h0);
		fire(5, 4'h0);
		check("en_off", cfg.chan_en, 32'h0);
		rd_reg(can_chan_pkg::OFS_EVENT_FLAGS, rv);
		check("normal", rv, 32'h60);
		wr_reg(can_chan_pkg::OFS_FLAG_CLEAR, 32'hEFF);
		fire(7, 4'h0);
		check("rf_irq", irq, 32'h1);
		fire(8, 4'h3);
		fire(5, 4'h0);
		rd_reg(can_chan_pkg::OFS_EVENT_FLAGS, rv);
		check("remote", rv, 32'h2A0);
		check("rf_dlc", cfg.dlc, 32'h3);
		wr_reg(can_chan_pkg::OFS_FLAG_CLEAR, 32'hEFF);
		// random masks against random events
		repeat (24) begin
			m = $urandom & 32'hFF;
			n = 4'($urandom_range(7, 0));
			wr_reg(can_chan_pkg::OFS_IRQ_ENABLE_CLEAR, ~m);
			wr_reg(can_chan_pkg::OFS_IRQ_ENABLE_SET, m);
			fire(n, 4'h0);
			check("rnd_irq", irq, {31'h0, m[n]});
			wr_reg(can_chan_pkg::OFS_FLAG_CLEAR, 32'hFF);
		end
		complete_run();
	end
endmodule : can_channel_status_irq_tb
